// ===== design/swl_slave.sv
// Bit-level signalling of a slave on an open-drain single-wire bus.
// Assumes an external pull-up and a synchronous dq_i; the byte layer sits outside.
// Contract
// - Transactions open with reset then presence.
// - Presence starts 15 to 60 us after rise.
// - Presence pulls low 60 to 240 us.
// - One bit per time slot.
// - Device samples 15 to 60 us in.
// - Device drives data only in read slots.
// - Zero pulls low, released before slot ends.
// - Read bit valid 15 us after fall.
// - Memory read shifted least significant first.
// - Busy conversion polls read zero, done one.
// - Supply query reads zero when bus powered.
`timescale 1ns/10ps
`default_nettype none
`include "swl_params.svh"
module swl_slave
    import swl_pkg::*;
#(
    parameter int RESET_CYC = `SWL_RESET_CYC
)
(
    // Clock and reset
    input  wire logic     clk,
    input  wire logic     rst_n,
    // Bus line, open drain
    input  wire logic     dq_i,
    output logic          dq_o,
    output logic          dq_oe,
    // Byte layer: slot direction and data
    input  wire logic     tx_mode,
    input  wire logic     tx_bit,
    output logic          tx_take,
    output logic          rx_valid,
    output logic          rx_bit,
    output logic          presence_done,
    output logic          bus_reset
);
    localparam int CW = `SWL_CNT_W;

    swl_line_if ev();

    swl_line_watch u_watch
    (
        .clk   (clk),
        .rst_n (rst_n),
        .dq_i  (dq_i),
        .ev    (ev)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Counter helper
    function automatic logic [CW-1:0] cyc(input int n);
        cyc = CW'(n);
    endfunction : cyc

    swl_state_t    st_q, st_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic [CW-1:0] low_q, low_d;
    logic          drv_q, drv_d;
    logic          rxv_q, rxv_d;
    logic          rxb_q, rxb_d;
    logic          take_q, take_d;
    logic          pdone_q, pdone_d;
    logic          brst_q, brst_d;
    logic          txm_q, txm_d;

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        st_d    = st_q;
        cnt_d   = cnt_q + cyc(1);
        drv_d   = drv_q;
        rxv_d   = 1'b0;
        rxb_d   = rxb_q;
        take_d  = 1'b0;
        pdone_d = 1'b0;
        brst_d  = 1'b0;
        txm_d   = txm_q;
        // Low-time meter, saturating; cleared while we drive so our own pulse
        // can never be mistaken for a master reset
        if (ev.line || drv_q)
            low_d = '0;
        else if (low_q != cyc(RESET_CYC))
            low_d = low_q + cyc(1);
        else
            low_d = low_q;

        if (!drv_q && low_q == cyc(RESET_CYC) - cyc(1) && !ev.line)
        begin
            // A reset-length low aborts any state; a drive of ours runs to its end first
            st_d   = SWL_RST_LOW;
            drv_d  = 1'b0;
            brst_d = 1'b1;
        end
        else
        begin
            case (st_q)
                SWL_IDLE:
                begin
                    drv_d = 1'b0;
                end
                SWL_RST_LOW:
                begin
                    if (ev.rise)
                    begin
                        st_d  = SWL_PWAIT;
                        cnt_d = '0;
                    end
                end
                SWL_PWAIT:
                begin
                    if (cnt_q == cyc(`SWL_PRES_WAIT_CYC) - cyc(1))
                    begin
                        st_d  = SWL_PDRIVE;
                        cnt_d = '0;
                        drv_d = 1'b1;
                    end
                end
                SWL_PDRIVE:
                begin
                    if (cnt_q == cyc(`SWL_PRES_LEN_CYC) - cyc(1))
                    begin
                        st_d    = SWL_SLOTEND;
                        drv_d   = 1'b0;
                        pdone_d = 1'b1;
                    end
                end
                SWL_SLOTEND:
                begin
                    // Wait for the line to be high before accepting a slot edge
                    if (ev.fall)
                    begin
                        st_d   = SWL_SLOT;
                        cnt_d  = '0;
                        txm_d  = tx_mode;
                        // Only the direction is kept; a read bit goes straight to the drive
                        take_d = 1'b1;
                        drv_d  = tx_mode & ~tx_bit;
                    end
                end
                SWL_SLOT:
                begin
                    if (txm_q)
                    begin
                        // Release at the end of the valid window, well before 60 us
                        if (cnt_q == cyc(`SWL_READ_HOLD_CYC) - cyc(1))
                        begin
                            drv_d = 1'b0;
                            st_d  = SWL_SLOTEND;
                        end
                    end
                    else if (cnt_q == cyc(`SWL_SAMPLE_CYC) - cyc(1))
                    begin
                        rxv_d = 1'b1;
                        rxb_d = ev.line;
                        st_d  = SWL_SLOTEND;
                    end
                end
                default:
                begin
                    st_d  = SWL_IDLE;
                    drv_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q    <= SWL_IDLE;
            cnt_q   <= '0;
            low_q   <= '0;
            drv_q   <= 1'b0;
            rxv_q   <= 1'b0;
            rxb_q   <= 1'b0;
            take_q  <= 1'b0;
            pdone_q <= 1'b0;
            brst_q  <= 1'b0;
            txm_q   <= 1'b0;
        end
        else
        begin
            st_q    <= st_d;
            cnt_q   <= cnt_d;
            low_q   <= low_d;
            drv_q   <= drv_d;
            rxv_q   <= rxv_d;
            rxb_q   <= rxb_d;
            take_q  <= take_d;
            pdone_q <= pdone_d;
            brst_q  <= brst_d;
            txm_q   <= txm_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign dq_o          = 1'b0;
    assign dq_oe         = drv_q;
    assign tx_take       = take_q;
    assign rx_valid      = rxv_q;
    assign rx_bit        = rxb_q;
    assign presence_done = pdone_q;
    assign bus_reset     = brst_q;
endmodule : swl_slave
`default_nettype wire

// ===== common/swl_params.svh
// Timing constants for the single-wire slave signalling block.
// Assumes a 125 MHz system clock; times are in ns and cycles are derived from them.
`ifndef SWL_PARAMS_SVH
`define SWL_PARAMS_SVH

`define SWL_CLK_NS          8
`define SWL_RESET_MIN_NS    480000
`define SWL_PRES_WAIT_NS    30000
`define SWL_PRES_LEN_NS     120000
`define SWL_SAMPLE_NS       30000
`define SWL_READ_HOLD_NS    15000
// Least times round up, longest times round down
`define SWL_RESET_CYC       ((`SWL_RESET_MIN_NS + `SWL_CLK_NS - 1) / `SWL_CLK_NS)
`define SWL_PRES_WAIT_CYC   ((`SWL_PRES_WAIT_NS + `SWL_CLK_NS - 1) / `SWL_CLK_NS)
`define SWL_PRES_LEN_CYC    ((`SWL_PRES_LEN_NS + `SWL_CLK_NS - 1) / `SWL_CLK_NS)
`define SWL_SAMPLE_CYC      ((`SWL_SAMPLE_NS + `SWL_CLK_NS - 1) / `SWL_CLK_NS)
`define SWL_READ_HOLD_CYC   (`SWL_READ_HOLD_NS / `SWL_CLK_NS)
`define SWL_CNT_W           17

`endif

// ===== common/swl_pkg.sv
// Types shared by the single-wire slave signalling block.
// Assumes nothing beyond a SystemVerilog compiler.
package swl_pkg;
    typedef enum logic [2:0]
    {
        SWL_IDLE    = 3'b000,
        SWL_RST_LOW = 3'b001,
        SWL_PWAIT   = 3'b010,
        SWL_PDRIVE  = 3'b011,
        SWL_SLOT    = 3'b100,
        SWL_SLOTEND = 3'b101
    } swl_state_t;
endpackage : swl_pkg

// ===== common/swl_line_if.sv
// Line edge events passed from the line watcher to the slot engine.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
`default_nettype none
interface swl_line_if;
    logic line;
    logic fall;
    logic rise;
    modport src (output line, output fall, output rise);
    modport dst (input line, input fall, input rise);
endinterface : swl_line_if
`default_nettype wire

// ===== design/swl_line_watch.sv
// Registers the bus line and flags falling and rising edges.
// Assumes the line input is already synchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module swl_line_watch
(
    // Clock and reset
    input  wire logic     clk,
    input  wire logic     rst_n,
    // Bus line
    input  wire logic     dq_i,
    // Edge events
    swl_line_if.src       ev
);
    logic prev_q;
    logic prev_d;

    always_comb
    begin
        prev_d = dq_i;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            prev_q <= 1'b1;
        else
            prev_q <= prev_d;
    end

    assign ev.line = dq_i;
    assign ev.fall = prev_q & ~dq_i;
    assign ev.rise = ~prev_q & dq_i;
endmodule : swl_line_watch
`default_nettype wire

// ===== tb/swl_slave_asserts.sv
// Port checker for swl_slave, bound into every instance.
// Assumes one clock and dq_i as the resolved line level.
`timescale 1ns/10ps
`default_nettype none
module swl_slave_asserts
#(parameter int RESET_CYC = 60000)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Line and byte layer
    input wire logic dq_i,
    input wire logic dq_oe,
    input wire logic tx_mode,
    input wire logic tx_bit,
    input wire logic tx_take,
    input wire logic rx_valid,
    input wire logic rx_bit,
    input wire logic presence_done,
    input wire logic bus_reset
);
    localparam int T15 = 1875;
    localparam int T60 = 7500;
    localparam int T240 = 30000;
    // Meters hi_q, lo_q and sf_q saturate so a long idle never wraps into a false window
    logic [15:0] hi_q, lo_q, sf_q, oe_q;
    logic        dq_q;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            {hi_q, lo_q, oe_q} <= '0;
            sf_q <= 16'hffff;
            dq_q <= 1'b1;
        end
        else
        begin
            hi_q <= dq_i ? hi_q + {15'h0, ~&hi_q} : 16'h0;
            lo_q <= (!dq_i && !dq_oe) ? lo_q + {15'h0, ~&lo_q} : 16'h0;
            oe_q <= dq_oe ? oe_q + 16'h1 : 16'h0;
            sf_q <= (dq_q && !dq_i) ? 16'h0 : sf_q + {15'h0, ~&sf_q};
            dq_q <= dq_i;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_quiet;
        (!dq_oe && !rx_valid && !tx_take) [*8];
    endsequence
    chk_oe_start: assert property (
        $rose(dq_oe) |-> hi_q == 16'h0 || (hi_q >= T15 && hi_q <= T60)) else $error("oe start");
    chk_read_take: assert property (
        $rose(dq_oe) && hi_q == 16'h0 |-> tx_take) else $error("oe without slot");
    chk_take_drive: assert property (
        tx_take |-> dq_oe == ($past(tx_mode) && !$past(tx_bit))) else $error("slot drive");
    chk_oe_len: assert property (
        $fell(dq_oe) |-> $past(oe_q) <= T15 + 1 || ($past(oe_q) >= T60 - 1 && $past(oe_q) <= T240))
        else $error("drive length");
    chk_pres_done: assert property (
        presence_done |-> $past(oe_q, 2) >= T60 - 1 && $past(oe_q, 2) <= T240) else $error("pres");
    chk_take_edge: assert property (
        tx_take |-> sf_q <= 16'h3) else $error("take late");
    chk_sample_win: assert property (
        rx_valid |-> sf_q >= T15 && sf_q <= T60 && rx_bit == dq_i) else $error("sample");
    chk_reset_len: assert property (
        bus_reset |-> lo_q + 3 >= RESET_CYC && lo_q <= RESET_CYC + 3) else $error("reset len");
    chk_abort_quiet: assert property (
        bus_reset |=> s_quiet) else $error("abort not quiet");
endmodule : swl_slave_asserts
bind swl_slave swl_slave_asserts #(.RESET_CYC(RESET_CYC)) swl_slave_asserts_inst
(
    .clk(clk), .rst_n(rst_n), .dq_i(dq_i), .dq_oe(dq_oe), .tx_mode(tx_mode),
    .tx_bit(tx_bit), .tx_take(tx_take), .rx_valid(rx_valid), .rx_bit(rx_bit),
    .presence_done(presence_done), .bus_reset(bus_reset)
);
`default_nettype wire

// ===== tb/swl_master_model.sv
// Bus master model: resets and time slots on the open-drain line.
// Assumes a 125 MHz clk and a pull-up resolving the wire in the bench.
`timescale 1ns/10ps
`default_nettype none
module swl_master_model
(
    // Clock and line
    input  wire logic clk,
    input  wire logic dq,
    // Master pull-down
    output var logic  low
);
    initial low = 1'b0;
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tk
    // Every slot is 60 us plus 1 us recovery; sample 8 us in, inside the 15 us
    task automatic slot(input logic b, output logic s);
        low = 1'b1;
        tk(125);
        low = !b;
        tk(875);
        s = dq;
        tk(6500);
        low = 1'b0;
        tk(125);
    endtask : slot
    task automatic rst(input int n, output logic [2:0] p);
        low = 1'b1;
        tk(n);
        low = 1'b0;
        tk(1875);
        p[2] = dq;
        tk(5725);
        p[1] = dq;
        tk(11400);
        p[0] = dq;
    endtask : rst
endmodule : swl_master_model
`default_nettype wire

// ===== tb/single_wire_slave_signaling_tb.sv
// Bench for swl_slave: master model on a pulled-up line, queue of bits.
// Assumes the design files and the master model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module single_wire_slave_signaling_tb;
    // Shortened reset, still above a 60 us write-zero low
    localparam int RST = 7600;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       tx_mode = 1'b0;
    logic       tx_bit = 1'b0;
    logic       low, dq_o, dq_oe, tx_take, rx_valid, rx_bit, pres, brst, s;
    logic [2:0] p;
    wire        dq;
    int         errors = 0;
    int         checks = 0;
    int         n_take = 0;
    int         n_pres = 0;
    int         n_rst = 0;
    logic       exq[$];
    always #4 clk = ~clk;
    assign dq = !(low || (dq_oe && !dq_o));
    swl_master_model swl_master_model_inst (.clk(clk), .dq(dq), .low(low));
    swl_slave #(.RESET_CYC(RST)) swl_slave_inst
    (
        .clk(clk), .rst_n(rst_n), .dq_i(dq), .dq_o(dq_o), .dq_oe(dq_oe), .tx_mode(tx_mode),
        .tx_bit(tx_bit), .tx_take(tx_take), .rx_valid(rx_valid), .rx_bit(rx_bit),
        .presence_done(pres), .bus_reset(brst)
    );
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e)
        begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic print_verdict;
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : print_verdict
    always @(negedge clk)
    begin
        n_take += (tx_take === 1'b1);
        n_pres += (pres === 1'b1);
        n_rst += (brst === 1'b1);
        if (rx_valid === 1'b1)
            chk(8'(rx_bit), 8'(exq.size() ? exq.pop_front() : 1'bx));
    end
    initial
    begin
        void'($urandom(32'hd0956c13));
        repeat (12) @(posedge clk);
        #1 rst_n = 1'b1;
        swl_master_model_inst.slot(1'b0, s);
        chk(8'(n_take), 8'h0);
        $display("idle test done");
        swl_master_model_inst.rst(RST + 100, p);
        chk(8'(p), 8'h05);
        chk(8'(n_pres), 8'h1);
        $display("presence test done");
        for (int i = 0; i < 5; i++)
        begin
            tx_mode = i[1];
            tx_bit = (i < 4) ? i[0] : 1'($urandom);
            if (!tx_mode)
                exq.push_back(tx_bit);
            swl_master_model_inst.slot(tx_mode | tx_bit, s);
            chk(8'(s), 8'(tx_bit));
            $display("slot %0d done", i);
        end
        chk(8'(n_take), 8'h5);
        chk(8'(exq.size()), 8'h0);
        chk(8'(dq_o), 8'h0);
        // Reset in a read-zero slot: meter waits out the device's own drive
        tx_mode = 1'b1;
        tx_bit = 1'b0;
        swl_master_model_inst.rst(RST + 2000, p);
        chk(8'(p), 8'h05);
        chk(8'(n_rst), 8'h2);
        chk(8'(n_pres), 8'h2);
        $display("abort test done");
        print_verdict();
    end
    initial
    begin
        repeat (115000) @(posedge clk);
        errors++;
        print_verdict();
    end
endmodule : single_wire_slave_signaling_tb
`default_nettype wire
